// File: sarseq_pkg.sv
/*
 package of the converter sequencer: register map, fields, reset
 values and machine-cycle timing. assumes a 10 mhz pclk.
*/
package sarseq_pkg;
  // ********************************
  // register map (byte addresses)
  // ********************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RESH_OFS = 8'h04;
  localparam logic [7:0] AUX_OFS = 8'h08;
  // ********************************
  // conversion control fields
  // ********************************
  localparam int CH_LSB = 0;
  localparam int START_BIT = 3;
  localparam int DONE_BIT = 4;
  localparam int EXT_EN_BIT = 5;
  localparam int RES0_BIT = 6;
  localparam int RES1_BIT = 7;
  // aux configuration fields
  localparam int IDLE_RUN_BIT = 6;
  localparam int SHORT_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h00;
  // ********************************
  // timing
  // ********************************
  localparam int CLK_NS = 100;
  localparam int MC_NS = 600;
  localparam int MC_CLKS = (MC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] MC_LAST = 3'(MC_CLKS - 1);
  // machine-cycle counts inside one conversion
  localparam logic [5:0] SAMP_FIRST = 6'h02;
  localparam logic [5:0] SAMP_LAST = 6'h09;
  localparam logic [5:0] BITS_FIRST = 6'h0a;
  localparam logic [1:0] BIT_MC_LAST = 2'h3;
  localparam logic [5:0] FULL_LAST = 6'h31;
  localparam logic [5:0] SHORT_LAST = 6'h17;
  localparam logic [9:0] SAR_MSB = 10'h200;
endpackage

// File: sarseq_top.sv
/*
 sequencer of a 10-bit successive-approximation converter with an
 8-bit short mode, reached over apb. assumes an analog mux, ladder
 dac and comparator outside, and cpu idle and power-down levels
 that are synchronous to pclk.
*/
// What this block does
// (R01) 10-bit straight-binary sar via 8-input mux
// (R02) short mode: 8 bits in 24 machine cycles
// (R03) full conversion takes 50 machine cycles
// (R04) idle: runs if idle_run_select, else powered off
// (R05) ext disabled: only software start works
// (R06) ext enabled: software or pin rising edge
// (R07) pin held low then high one cycle each
// (R08) pin edge seen at cycle end, start next
// (R09) software start begins at next machine cycle
// (R10) start bit: command flop and status flop
// (R11) two init cycles; status set after first
// (R12) sample selected input eight machine cycles
// (R13) msb first; keep bit if input above dac
// (R14) each bit test takes four machine cycles in full mode (three for the msb), one in short mode
// (R15) result high byte plus two low bits
// (R16) done set, status cleared, fifty cycles after (24 in short mode)
// (R17) low three control bits select channel
// (R18) starts ignored while converting
// (R19) power-down, or idle without run select, aborts running conversion
// (R20) result held while done flag set
// (R21) done cleared only by software; raises interrupt
// (R22) reset: idle, start flops and done cleared
`timescale 1ns/1ns
module sarseq_top
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu power state
  input wire logic idle_mode,
  input wire logic power_down,
  // start pin and comparator
  input wire logic ext_start_pin,
  input wire logic comp_in_high,
  // analog front end
  output logic [2:0] mux_sel,
  output logic sample_en,
  output logic [9:0] dac_code,
  output logic adc_power_on,
  // completion interrupt
  output logic conv_done_irq
);
  import sarseq_pkg::*;

  // ********************************
  // state
  // ********************************
  logic [2:0] div_reg; // pclk count in a machine cycle
  logic tick_reg; // one pulse per machine cycle
  logic [2:0] pin_sync_reg; // start pin synchroniser
  logic pin_lvl_reg; // filtered pin level
  logic pin_prev_reg; // pin level at last cycle end
  logic [2:0] cmp_sync_reg; // comparator synchroniser
  logic cmp_lvl_reg; // filtered comparator
  logic [2:0] ch_reg; // channel select
  logic ext_en_reg; // pin start allowed
  logic cmd_reg; // start command flop
  logic status_reg; // start status flop
  logic done_reg; // completion flag
  logic [1:0] res_lo_reg; // two low result bits
  logic [7:0] res_hi_reg; // high result byte
  logic short_cfg_reg; // short mode select
  logic idle_run_reg; // run during idle
  logic run_reg; // conversion in progress
  logic short_run_reg; // mode latched at start
  logic [5:0] mc_reg; // machine cycles since start
  logic [1:0] sub_reg; // cycle within a bit test
  logic [9:0] sar_reg; // approximation register
  logic [9:0] ptr_reg; // bit under test
  logic samp_reg; // sampling switch
  logic pwr_reg; // converter powered
  logic rdy_reg; // apb ready
  logic err_reg; // apb error
  logic [31:0] rd_reg; // apb read data

  // ********************************
  // combinational helpers
  // ********************************
  logic power_ok; // converter may run now
  logic wr_acc; // apb write taking effect
  logic map_hit; // address is mapped
  logic pin_edge; // rising edge at cycle end
  logic last_mc; // final cycle of conversion
  logic [7:0] ctrl_rd; // control read view

  // off when powered down, or idle without run select
  assign power_ok = !power_down && !(idle_mode && !idle_run_reg); // [R04]
  assign wr_acc = psel && penable && rdy_reg && pwrite;
  assign map_hit = (paddr == CTRL_OFS) || (paddr == RESH_OFS) ||
                   (paddr == AUX_OFS);
  // edge judged only at the end of a machine cycle
  assign pin_edge = tick_reg && pin_lvl_reg && !pin_prev_reg; // [R08]
  assign last_mc = short_run_reg ? (mc_reg == SHORT_LAST) :
                   (mc_reg == FULL_LAST);
  // start reads back from the status flop, not the command
  assign ctrl_rd = {res_lo_reg[1], res_lo_reg[0], ext_en_reg,
                    done_reg, status_reg, ch_reg}; // [R10]

  // ********************************
  // machine-cycle divider
  // ********************************
  // produces one tick every machine cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == MC_LAST);
      if (div_reg == MC_LAST) begin
        div_reg <= 3'h0;
      end else begin
        div_reg <= div_reg + 3'h1;
      end
    end
  end

  // ********************************
  // pin synchronisers
  // ********************************
  // three stages; level moves once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_reg <= 3'h0;
      pin_lvl_reg <= 1'b0;
      pin_prev_reg <= 1'b1; // idle high: no false edge after reset
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], ext_start_pin};
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_lvl_reg <= pin_sync_reg[2];
      end
      // low and high must each span a cycle end to count
      if (tick_reg) begin
        pin_prev_reg <= pin_lvl_reg; // [R07]
      end
    end
  end

  // comparator output is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_sync_reg <= 3'h0;
      cmp_lvl_reg <= 1'b0;
    end else begin
      cmp_sync_reg <= {cmp_sync_reg[1:0], comp_in_high};
      if (cmp_sync_reg[1] == cmp_sync_reg[2]) begin
        cmp_lvl_reg <= cmp_sync_reg[2];
      end
    end
  end

  // ********************************
  // apb slave
  // ********************************
  // one wait-free access; error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
      rd_reg <= 32'h0;
    end else begin
      rdy_reg <= psel && !penable;
      err_reg <= psel && !penable && !map_hit;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          CTRL_OFS: rd_reg <= {24'h0, ctrl_rd};
          RESH_OFS: rd_reg <= {24'h0, res_hi_reg};
          AUX_OFS: rd_reg <= {24'h0, short_cfg_reg, idle_run_reg,
                              6'h0};
          default: rd_reg <= 32'h0;
        endcase
      end
    end
  end

  // writable configuration fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_reg <= CTRL_RST[2:0];
      ext_en_reg <= CTRL_RST[EXT_EN_BIT];
      short_cfg_reg <= AUX_RST[SHORT_BIT];
      idle_run_reg <= AUX_RST[IDLE_RUN_BIT];
    end else if (wr_acc) begin
      if (paddr == CTRL_OFS) begin
        ch_reg <= pwdata[CH_LSB +: 3]; // [R17]
        ext_en_reg <= pwdata[EXT_EN_BIT];
      end else if (paddr == AUX_OFS) begin
        short_cfg_reg <= pwdata[SHORT_BIT];
        idle_run_reg <= pwdata[IDLE_RUN_BIT];
      end
    end
  end

  // ********************************
  // start command flop
  // ********************************
  // set by software or enabled pin edge, taken at cycle end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 1'b0; // [R22]
    end else if (!power_ok) begin
      cmd_reg <= 1'b0; // [R19]
    end else if (run_reg) begin
      cmd_reg <= 1'b0; // [R18]
    end else if (tick_reg && cmd_reg) begin
      cmd_reg <= 1'b0;
    end else if (wr_acc && paddr == CTRL_OFS &&
                 pwdata[START_BIT]) begin
      cmd_reg <= 1'b1; // [R05] [R09] [R10]
    end else if (ext_en_reg && pin_edge) begin
      cmd_reg <= 1'b1; // [R06]
    end
  end

  // ********************************
  // conversion sequencer
  // ********************************
  // counts machine cycles from start to completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0; // [R22]
      short_run_reg <= 1'b0;
      mc_reg <= 6'h0;
      sub_reg <= 2'h0;
    end else if (!power_ok) begin
      run_reg <= 1'b0; // [R19]
    end else if (tick_reg) begin
      // a pin edge starts at the very tick that judged it
      if (!run_reg && (cmd_reg || (ext_en_reg && pin_edge))) begin
        run_reg <= 1'b1; // [R08] [R09]
        short_run_reg <= short_cfg_reg;
        mc_reg <= 6'h0;
        sub_reg <= 2'h0;
      end else if (run_reg) begin
        if (last_mc) begin
          run_reg <= 1'b0; // [R03] [R02]
        end
        mc_reg <= mc_reg + 6'h1;
        // bit-test slots are four cycles in full mode
        if (mc_reg >= SAMP_LAST) begin
          sub_reg <= sub_reg + 2'h1; // [R14]
        end
      end
    end
  end

  // status flop: set after first init cycle, cleared at end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 1'b0; // [R22]
    end else if (!power_ok) begin
      status_reg <= 1'b0; // [R19]
    end else if (tick_reg && run_reg) begin
      if (last_mc) begin
        status_reg <= 1'b0; // [R16]
      end else if (mc_reg == 6'h0) begin
        status_reg <= 1'b1; // [R11]
      end
    end
  end

  // sampling switch closed for eight machine cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_reg <= 1'b0;
    end else if (!power_ok || !run_reg) begin
      samp_reg <= 1'b0;
    end else if (tick_reg) begin
      samp_reg <= (mc_reg >= 6'h1) && (mc_reg < SAMP_LAST); // [R12]
    end
  end

  // ********************************
  // successive approximation
  // ********************************
  // msb loaded first, each slot keeps or clears its bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_reg <= 10'h0;
      ptr_reg <= 10'h0;
    end else if (tick_reg && run_reg && power_ok) begin
      if (mc_reg == SAMP_LAST) begin
        sar_reg <= SAR_MSB; // [R13]
        ptr_reg <= SAR_MSB;
      end else if (mc_reg >= BITS_FIRST && ptr_reg != 10'h0 &&
                   (short_run_reg ? ptr_reg[1] == 1'b0 :
                    sub_reg == BIT_MC_LAST)) begin
        // short mode tests one bit per cycle down to bit 2
        sar_reg <= (cmp_lvl_reg ? sar_reg : (sar_reg & ~ptr_reg)) |
                   (ptr_reg >> 1); // [R01] [R13]
        ptr_reg <= ptr_reg >> 1;
      end
    end
  end

  // ********************************
  // completion and result
  // ********************************
  // hardware only sets done; software may only clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0; // [R22]
    end else if (tick_reg && run_reg && power_ok && last_mc) begin
      done_reg <= 1'b1; // [R16]
    end else if (wr_acc && paddr == CTRL_OFS &&
                 !pwdata[DONE_BIT]) begin
      done_reg <= 1'b0; // [R21]
    end
  end

  // result stored only when the previous one is consumed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_hi_reg <= 8'h0;
      res_lo_reg <= 2'h0;
    end else if (tick_reg && run_reg && power_ok && last_mc &&
                 !done_reg) begin // [R20]
      res_hi_reg <= sar_reg[9:2]; // [R15] [R02]
      res_lo_reg <= short_run_reg ? 2'h0 : sar_reg[1:0]; // [R15]
    end
  end

  // power state of the analog part
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg <= 1'b0;
    end else begin
      pwr_reg <= power_ok; // [R04]
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign prdata = rd_reg;
  assign pready = rdy_reg;
  assign pslverr = err_reg;
  assign mux_sel = ch_reg; // [R17]
  assign sample_en = samp_reg;
  assign dac_code = sar_reg;
  assign adc_power_on = pwr_reg;
  assign conv_done_irq = done_reg; // [R21]

  // ********************************
  // assertions
  // ********************************
  AST_FULL_END: assert property (@(posedge pclk) disable iff (!presetn)
    tick_reg && run_reg && power_ok && !short_run_reg &&
    mc_reg == FULL_LAST |=> done_reg && !status_reg && !run_reg) // [R03]
    else $error("full conversion did not end at cycle 50");
  AST_SHORT_END: assert property (@(posedge pclk) disable iff (!presetn)
    tick_reg && run_reg && power_ok && short_run_reg &&
    mc_reg == SHORT_LAST |=> done_reg && !run_reg) // [R02]
    else $error("short conversion did not end at cycle 24");
  AST_STATUS_SET: assert property (@(posedge pclk) disable iff (!presetn)
    tick_reg && run_reg && power_ok && mc_reg == 6'h0
    |=> status_reg) // [R11]
    else $error("status not set after first init cycle");
  AST_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn)
    tick_reg && run_reg && power_ok && mc_reg == 6'h1
    |=> sample_en ##1 sample_en) // [R12]
    else $error("sampling did not open after init");
  AST_MSB_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    tick_reg && run_reg && power_ok && mc_reg == SAMP_LAST
    |=> dac_code == SAR_MSB) // [R13]
    else $error("approximation did not start with msb");
  AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
    !power_ok |=> !run_reg && !status_reg) // [R19]
    else $error("conversion not aborted on power state");
  AST_KEEP_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    run_reg && power_ok && !tick_reg |=> run_reg) // [R18]
    else $error("running conversion disturbed");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    done_reg |=> $stable(res_hi_reg) && $stable(res_lo_reg)) // [R20]
    else $error("result changed while done set");
  AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    done_reg && !wr_acc |=> done_reg) // [R21]
    else $error("done cleared without software write");
  AST_IDLE_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    idle_mode && idle_run_reg && !power_down |=> adc_power_on) // [R04]
    else $error("converter off in idle with run select");
endmodule // sarseq_top

// File: sarseq_front.sv
/*
 model of the analog front end seen by the converter sequencer:
 channel mux, sample-and-hold and comparator. assumes the bench sets
 one 10-bit level code per channel and that pclk runs meanwhile.
*/
`timescale 1ns/1ns
module sarseq_front (
  // clock
  input wire logic pclk,
  // converter side
  input wire logic [2:0] mux_sel,
  input wire logic sample_en,
  input wire logic [9:0] dac_code,
  input wire logic adc_power_on,
  // analog levels as codes, one a channel
  input wire logic [9:0] chan_level [8],
  // comparator
  output logic comp_in_high
);
  // ********************************
  // sample and compare
  // ********************************
  logic [9:0] held_level; // charge on the sampling capacitor
  logic wobble = 1'b0; // unpowered comparator output changes freely
  // track the selected channel only while the switch is closed
  always @(posedge pclk) begin
    if (sample_en) begin
      held_level <= chan_level[mux_sel];
    end
    wobble <= ~wobble;
  end
  // high when the held input lies above the ladder tap
  assign comp_in_high = adc_power_on ? (held_level > dac_code) : wobble;
endmodule // sarseq_front

// File: sar_adc_sequencer_bench.sv
/*
 self-checking bench of the converter sequencer: apb master, start
 pin driver and analog model. assumes the package timing constants
 and a 100 ns pclk.
*/
`timescale 1ns/1ns
module sar_adc_sequencer_bench;
  import sarseq_pkg::*;
  // ********************************
  // signals
  // ********************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic idle_mode, power_down, ext_start_pin, comp_in_high, er;
  logic [2:0] mux_sel;
  logic sample_en, adc_power_on, conv_done_irq;
  logic [9:0] dac_code, cx;
  logic [9:0] chan_level [8];
  int fails = 0;
  int comparisons = 0;
  int cycles = 0; // timeout count
  int n;
  // clock
  always #50 pclk = ~pclk;
  sarseq_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .power_down(power_down),
    .ext_start_pin(ext_start_pin), .comp_in_high(comp_in_high),
    .mux_sel(mux_sel), .sample_en(sample_en), .dac_code(dac_code),
    .adc_power_on(adc_power_on), .conv_done_irq(conv_done_irq));
  sarseq_front front (.pclk(pclk), .mux_sel(mux_sel),
    .sample_en(sample_en), .dac_code(dac_code),
    .adc_power_on(adc_power_on), .chan_level(chan_level),
    .comp_in_high(comp_in_high));
  // ********************************
  // tasks and functions
  // ********************************
  task test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      test_done();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask
  task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, er);
    chk(what, exp, rd);
  endtask
  // wait for the done flag, bounded
  task wait_done(input int lim);
    n = 0;
    while (conv_done_irq !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // pin low for two machine cycles, then high
  task pin_pulse;
    ext_start_pin <= 1'b0;
    repeat (2 * MC_CLKS) @(posedge pclk);
    ext_start_pin <= 1'b1;
  endtask
  // successive approximation, bit kept when input above trial
  function logic [9:0] sar_code(input logic [9:0] v, input int lsb);
    logic [9:0] c;
    logic [9:0] t;
    c = 10'h000;
    for (int b = 9; b >= lsb; b--) begin
      t = c | (10'h001 << b);
      if (v > t) begin
        c = t;
      end
    end
    return c;
  endfunction
  // one conversion with timing, status and result checks
  task convert(input logic [2:0] ch, input logic sh, input logic ext,
               input logic pin, input logic keep);
    time t0;
    int lo;
    int hi;
    logic [9:0] c;
    lo = (sh ? 24 : 50) * MC_CLKS;
    hi = lo + (pin ? 2 * MC_CLKS + 2 : MC_CLKS + 2);
    wr(AUX_OFS, {24'h0, sh, 7'h00});
    // levels written just before the call have settled by now
    c = sar_code(chan_level[ch], sh ? 2 : 0);
    if (pin) begin
      wr(CTRL_OFS, {26'h0, ext, 2'b00, ch});
      pin_pulse();
    end else begin
      wr(CTRL_OFS, {26'h0, ext, 2'b01, ch});
    end
    t0 = $time;
    repeat (3 * MC_CLKS) @(posedge pclk);
    apb(1'b0, CTRL_OFS, 32'h0, rd, er);
    chk("status", 32'h8, rd & 32'h18);
    wait_done(hi + MC_CLKS);
    n = int'(($time - t0) / CLK_NS);
    chk("conv time", 32'h1, {31'h0, n >= lo && n <= hi});
    rdc("result high", RESH_OFS, {24'h0, c[9:2]});
    rdc("control", CTRL_OFS, {24'h0, sh ? 2'b00 : c[1:0], 2'b01, 1'b0, ch}
      | {26'h0, ext, 5'h0});
    chk("mux", {29'h0, ch}, {29'h0, mux_sel});
    if (!keep) begin
      wr(CTRL_OFS, {26'h0, ext, 2'b00, ch});
      @(posedge pclk);
      chk("irq clear", 32'h0, {31'h0, conv_done_irq});
    end
  endtask
  // ********************************
  // main sequence
  // ********************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    idle_mode = 1'b0;
    power_down = 1'b0;
    ext_start_pin = 1'b1;
    foreach (chan_level[k]) chan_level[k] = 10'h000;
    void'($urandom(69799));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl reset", CTRL_OFS, {24'h0, CTRL_RST});
    rdc("aux reset", AUX_OFS, {24'h0, AUX_RST});
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    // random conversions, first two at the scale ends
    for (int i = 0; i < 12; i++) begin
      foreach (chan_level[k]) begin
        chan_level[k] <= i == 0 ? 10'h000 : i == 1 ? 10'h3ff
          : 10'($urandom_range(1023, 0));
      end
      cx[0] = 1'($urandom_range(1, 0));
      cx[1] = 1'($urandom_range(1, 0));
      convert(3'($urandom_range(7, 0)), cx[0], cx[1],
        cx[1] & 1'($urandom_range(1, 0)), 1'b0);
    end
    // pin ignored while external start is off
    wr(CTRL_OFS, 32'h1);
    pin_pulse();
    wait_done(70 * MC_CLKS);
    chk("pin ignored", 32'h0, {31'h0, conv_done_irq});
    // restarts ignored, idle with run select keeps converting
    wr(AUX_OFS, 32'h40);
    wr(CTRL_OFS, 32'h2a);
    repeat (20 * MC_CLKS) @(posedge pclk);
    wr(CTRL_OFS, 32'h2a);
    pin_pulse();
    idle_mode <= 1'b1;
    wait_done(35 * MC_CLKS);
    n = n + 20 * MC_CLKS + 3 + 2 * MC_CLKS + 1;
    chk("no restart", 32'h1, {31'h0, n >= 300 && n <= 300 + MC_CLKS + 4});
    idle_mode <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    // idle without run select, then power-down, abort
    for (int m = 0; m < 2; m++) begin
      wr(AUX_OFS, 32'h0);
      wr(CTRL_OFS, 32'h8);
      repeat (20 * MC_CLKS) @(posedge pclk);
      idle_mode <= m == 0;
      power_down <= m == 1;
      repeat (3) @(posedge pclk);
      chk("powered off", 32'h0, {31'h0, adc_power_on});
      idle_mode <= 1'b0;
      power_down <= 1'b0;
      wait_done(60 * MC_CLKS);
      chk("aborted", 32'h0, {31'h0, conv_done_irq});
    end
    // result held while done stays set
    foreach (chan_level[k]) chan_level[k] <= 10'h155;
    convert(3'h3, 1'b0, 1'b0, 1'b0, 1'b1);
    cx = sar_code(10'h155, 0);
    foreach (chan_level[k]) chan_level[k] <= 10'h2aa;
    wr(CTRL_OFS, 32'h1b);
    repeat (54 * MC_CLKS) @(posedge pclk);
    rdc("result kept", RESH_OFS, {24'h0, cx[9:2]});
    wr(CTRL_OFS, 32'h3);
    wr(CTRL_OFS, 32'h13);
    @(posedge pclk);
    chk("done not set by write", 32'h0, {31'h0, conv_done_irq});
    test_done();
  end
endmodule // sar_adc_sequencer_bench
